// [include/can_fault_pkg.sv]
// constants and types shared by the bus fault manager
package can_fault_pkg;
   // register byte offsets on the apb port
   localparam logic [7:0] CAN_CTRL_OFS = 8'h00;
   localparam logic [7:0] RESET_CTRL_OFS = 8'h04;
   localparam logic [7:0] IO_CTRL_OFS = 8'h08;
   localparam logic [7:0] FAULT_STAT_OFS = 8'h0c;
   // can control register fields
   localparam int MODE_LSB = 0;
   localparam int VARIANT_BIT = 2;
   // reset control register fields
   localparam int WAKE_FLAG_BIT = 0;
   localparam int STUCK_FLAG_BIT = 1;
   // io control register fields
   localparam int GS_SEL_LSB = 0;
   localparam int SHIFT_BIT = 2;
   // fault status register fields
   localparam int OW_H_BIT = 0;
   localparam int OW_L_BIT = 1;
   localparam int FLT_H_BIT = 2;
   localparam int FLT_L_BIT = 3;
   localparam int FLT_L5V_BIT = 4;
   // reset values
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic VARIANT_RST = 1'b1;
   localparam logic [1:0] GS_SEL_RST = 2'h0;
   // timing, figures in ns, cycles derived from the clock period
   localparam int CLK_PERIOD_NS = 100;
   localparam int STUCK_TIME_NS = 750000;
   localparam int STUCK_CYC = (STUCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TX_REC_TIME_NS = 32000;
   localparam int TX_REC_CYC = (TX_REC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_TIME_NS = 16000;
   localparam int WAKE_CYC = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OW_WIN_NS = 1000;
   localparam int OW_WIN_CYC = OW_WIN_NS / CLK_PERIOD_NS;
   localparam int FLT_TIME_NS = 10000;
   localparam int FLT_CYC = (FLT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] OW_LIMIT = 3'h4;
   // interface and chip modes
   typedef enum logic [1:0] {MODE_TRANSMIT_RECEIVE_MODE, MODE_RXONLY, MODE_BATTERY_TERMINATED_MODE} can_mode_t;
   typedef enum logic [1:0] {SBC_NORMAL, SBC_STANDBY, SBC_STOP, SBC_SLEEP} sbc_mode_t;
endpackage : can_fault_pkg

// [verilog/can_fault_manager.sv]
// bus fault manager of a fault tolerant low speed can transceiver
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module can_fault_manager #(
   parameter int STUCK_CYCLES = can_fault_pkg::STUCK_CYC, // stuck dominant timeout
   parameter int FILT_CYCLES = can_fault_pkg::FLT_CYC     // fault detect/recover filter
) (
   input wire logic SYS_CLK_I,                     // 10 mhz system clock
   input wire logic SYS_RST_I,                     // synchronous reset, high
   input wire logic PSEL_I,                        // apb select
   input wire logic PENABLE_I,                     // apb enable
   input wire logic PWRITE_I,                      // apb direction
   input wire logic [7:0] PADDR_I,                 // apb byte address
   input wire logic [31:0] PWDATA_I,               // apb write data
   output logic [31:0] PRDATA_O,                   // apb read data
   output logic PREADY_O,                          // apb ready
   output logic PSLVERR_O,                         // apb error, unmapped
   input wire can_fault_pkg::sbc_mode_t SBC_MODE_I, // chip power mode
   input wire logic TXD_I,                         // transmit pin, low dominant
   input wire logic DIFF_DOM_I,                    // differential receiver dominant
   input wire logic [1:0] SE_DOM_I,                // single-ended dominant, [0] high, [1] low
   input wire logic WAKE_DOM_I,                    // wake comparator sees dominant
   input wire logic HIGH_SHORT_I,                  // high line to 5v or battery
   input wire logic LOW_SHORT_I,                   // low line to gnd, high or battery
   input wire logic LOW_5V_I,                      // low line to 5v
   input wire logic [3:0] GS_BELOW_I,              // high line below each shift level
   output logic RXD_O,                             // receive pin, low dominant
   output logic HIGH_DRV_O,                        // high line driver on
   output logic LOW_DRV_O,                         // low line driver on
   output logic HIGH_TERM_EN_O,                    // high line termination switch
   output logic LOW_TERM_EN_O,                     // low line termination switch
   output logic NORMAL_REQ_O,                      // pulse: go to normal request
   output logic WAKE_INT_O                         // pulse: wake interrupt
);
   import can_fault_pkg::*;

   localparam int SW = 11;
   localparam int CW = 16;
   localparam logic [CW-1:0] STUCK_LIM = CW'(STUCK_CYCLES);
   localparam logic [CW-1:0] TXREC_LIM = CW'(TX_REC_CYC);
   localparam logic [CW-1:0] WAKE_LIM = CW'(WAKE_CYC);
   localparam logic [CW-1:0] FILT_LIM = CW'(FILT_CYCLES);
   localparam logic [3:0] WIN_LIM = 4'(OW_WIN_CYC);

   typedef struct packed {
      logic [SW-1:0] s1;
      logic [SW-1:0] s2;
      logic txd_d;
      logic diff_d;
      logic [1:0] se_d;
      logic [1:0][3:0] win_cnt;
      logic [1:0] win_act;
      logic [1:0] se_tog;
      logic [1:0][2:0] ow_cnt;
      logic [1:0] ow_flag;
      logic [2:0][CW-1:0] flt_cnt;
      logic [2:0] flt;
      logic [CW-1:0] tx_cnt;
      logic stuck;
      logic [CW-1:0] wake_cnt;
      logic wake_act;
      logic [1:0] mode;
      logic later;
      logic [1:0] gs_sel;
      logic shift;
      logic wake_flag;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic rxd;
      logic hdrv;
      logic ldrv;
      logic hterm;
      logic lterm;
      logic nreq;
      logic wint;
   } state_t;

   state_t cur_ff;
   state_t nxt_ff;

   // synchronised pin view, read only from the second stage
   logic txd_s;
   logic diff_s;
   logic [1:0] se_s;
   logic wake_s;
   logic [2:0] flt_in;
   logic gs0_s1_ff;
   logic gs0_s2_ff;
   logic [3:0] gs_s;
   assign txd_s = cur_ff.s2[0];
   assign diff_s = cur_ff.s2[1];
   assign se_s = cur_ff.s2[3:2];
   assign wake_s = cur_ff.s2[4];
   assign flt_in = cur_ff.s2[7:5];
   assign gs_s = {cur_ff.s2[10:8], gs0_s2_ff};

   // ground shift level 0 has a synchroniser of its own, outside the state struct
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         gs0_s1_ff <= 1'b0;
         gs0_s2_ff <= 1'b0;
      end else begin
         gs0_s1_ff <= GS_BELOW_I[0];
         gs0_s2_ff <= gs0_s1_ff;
      end
   end

   // next state of the whole state struct
   always_comb begin
      logic eff_battery_terminated_mode;
      logic listening;
      logic diff_edge;
      logic wr;
      logic rd_setup;
      logic wake_evt;
      logic [3:0] gs_all;
      nxt_ff = cur_ff;
      eff_battery_terminated_mode = 1'b0;
      listening = 1'b0;
      diff_edge = 1'b0;
      wr = 1'b0;
      rd_setup = 1'b0;
      wake_evt = 1'b0;
      gs_all = gs_s;

      // two-stage synchronisers
      nxt_ff.s1 = {GS_BELOW_I[3:1], LOW_5V_I, LOW_SHORT_I, HIGH_SHORT_I, WAKE_DOM_I, SE_DOM_I, DIFF_DOM_I, TXD_I};
      nxt_ff.s2 = cur_ff.s1;
      nxt_ff.txd_d = txd_s;
      nxt_ff.diff_d = diff_s;
      nxt_ff.se_d = se_s;
      nxt_ff.nreq = 1'b0;
      nxt_ff.wint = 1'b0;

      // low power chip modes force battery termination
      eff_battery_terminated_mode = (cur_ff.mode == MODE_BATTERY_TERMINATED_MODE) || (SBC_MODE_I == SBC_STOP) || (SBC_MODE_I == SBC_SLEEP);
      listening = !eff_battery_terminated_mode;

      // fault filters: same delay for detection and recovery
      for (int f = 0; f < 3; f++) begin
         if (!listening || flt_in[f] == cur_ff.flt[f]) begin
            nxt_ff.flt_cnt[f] = '0;
            if (!listening) begin
               nxt_ff.flt[f] = 1'b0;
            end
         end else if (cur_ff.flt_cnt[f] >= FILT_LIM - CW'(1)) begin
            nxt_ff.flt_cnt[f] = '0;
            nxt_ff.flt[f] = flt_in[f];
         end else begin
            nxt_ff.flt_cnt[f] = cur_ff.flt_cnt[f] + CW'(1);
         end
      end

      // open wire check per line, only when not transmitting
      diff_edge = diff_s != cur_ff.diff_d;
      for (int i = 0; i < 2; i++) begin
         if (!listening || !txd_s) begin
            nxt_ff.win_act[i] = 1'b0;
         end else if (diff_edge && !cur_ff.win_act[i]) begin
            nxt_ff.win_act[i] = 1'b1;
            nxt_ff.win_cnt[i] = '0;
            nxt_ff.se_tog[i] = se_s[i] != cur_ff.se_d[i];
         end else if (cur_ff.win_act[i]) begin
            if (se_s[i] != cur_ff.se_d[i]) begin
               nxt_ff.se_tog[i] = 1'b1;
            end
            nxt_ff.win_cnt[i] = cur_ff.win_cnt[i] + 4'h1;
            if (cur_ff.win_cnt[i] >= WIN_LIM - 4'h1) begin
               nxt_ff.win_act[i] = 1'b0;
               if (!cur_ff.ow_flag[i]) begin
                  if (!cur_ff.se_tog[i] && se_s[i] == cur_ff.se_d[i]) begin
                     nxt_ff.ow_cnt[i] = cur_ff.ow_cnt[i] + 3'h1;
                     if (cur_ff.ow_cnt[i] + 3'h1 >= OW_LIMIT) begin
                        nxt_ff.ow_flag[i] = 1'b1;
                     end
                  end
               end else if (se_s[i]) begin
                  nxt_ff.ow_cnt[i] = cur_ff.ow_cnt[i] - 3'h1;
                  if (cur_ff.ow_cnt[i] <= 3'h1) begin
                     nxt_ff.ow_cnt[i] = '0;
                     nxt_ff.ow_flag[i] = 1'b0;
                  end
               end else if (cur_ff.later && cur_ff.ow_cnt[i] < OW_LIMIT) begin
                  nxt_ff.ow_cnt[i] = cur_ff.ow_cnt[i] + 3'h1;
               end
            end
         end
      end

      // stuck dominant timeout and recovery on the tx input
      if (!cur_ff.stuck) begin
         nxt_ff.tx_cnt = txd_s ? '0 : cur_ff.tx_cnt + CW'(1);
         if (!txd_s && cur_ff.tx_cnt >= STUCK_LIM - CW'(1)) begin
            nxt_ff.stuck = 1'b1;
            nxt_ff.tx_cnt = '0;
         end
      end else begin
         nxt_ff.tx_cnt = txd_s ? cur_ff.tx_cnt + CW'(1) : '0;
         if (txd_s && cur_ff.tx_cnt >= TXREC_LIM) begin
            nxt_ff.stuck = 1'b0;
            nxt_ff.tx_cnt = '0;
         end
      end

      // wake filter on the wake comparator
      if (!eff_battery_terminated_mode || !wake_s) begin
         nxt_ff.wake_cnt = '0;
         nxt_ff.wake_act = 1'b0;
      end else if (!cur_ff.wake_act) begin
         nxt_ff.wake_cnt = cur_ff.wake_cnt + CW'(1);
         if (cur_ff.wake_cnt >= WAKE_LIM - CW'(1)) begin
            nxt_ff.wake_act = 1'b1;
            wake_evt = 1'b1;
         end
      end
      if (wake_evt && SBC_MODE_I == SBC_SLEEP) begin
         nxt_ff.nreq = 1'b1;
      end
      if (wake_evt && SBC_MODE_I == SBC_STOP) begin
         nxt_ff.wint = 1'b1;
      end

      // ground shift result replaced at each tx falling edge while listening, unfiltered
      if (cur_ff.txd_d && !txd_s && listening) begin
         nxt_ff.shift = gs_all[cur_ff.gs_sel];
      end

      // apb: registered answer, ready in the access cycle
      rd_setup = PSEL_I && !PENABLE_I;
      wr = PSEL_I && PENABLE_I && cur_ff.pready && PWRITE_I && !cur_ff.pslverr;
      nxt_ff.pready = rd_setup;
      nxt_ff.pslverr = 1'b0;
      nxt_ff.prdata = '0;
      if (rd_setup) begin
         unique case (PADDR_I)
            CAN_CTRL_OFS: begin
               nxt_ff.prdata[MODE_LSB +: 2] = cur_ff.mode;
               nxt_ff.prdata[VARIANT_BIT] = cur_ff.later;
            end
            RESET_CTRL_OFS: begin
               nxt_ff.prdata[WAKE_FLAG_BIT] = cur_ff.wake_flag;
               nxt_ff.prdata[STUCK_FLAG_BIT] = cur_ff.stuck;
            end
            IO_CTRL_OFS: begin
               nxt_ff.prdata[GS_SEL_LSB +: 2] = cur_ff.gs_sel;
               nxt_ff.prdata[SHIFT_BIT] = cur_ff.shift;
            end
            FAULT_STAT_OFS: begin
               nxt_ff.prdata[OW_H_BIT] = cur_ff.ow_flag[0];
               nxt_ff.prdata[OW_L_BIT] = cur_ff.ow_flag[1];
               nxt_ff.prdata[FLT_H_BIT] = cur_ff.flt[0];
               nxt_ff.prdata[FLT_L_BIT] = cur_ff.flt[1];
               nxt_ff.prdata[FLT_L5V_BIT] = cur_ff.flt[2];
            end
            default: nxt_ff.pslverr = 1'b1;
         endcase
      end
      if (wr && PADDR_I == CAN_CTRL_OFS) begin
         nxt_ff.mode = PWDATA_I[MODE_LSB +: 2];
         nxt_ff.later = PWDATA_I[VARIANT_BIT];
      end
      if (wr && PADDR_I == IO_CTRL_OFS) begin
         nxt_ff.gs_sel = PWDATA_I[GS_SEL_LSB +: 2];
      end
      // wake flag: write one to clear, a new wake wins
      if (wr && PADDR_I == RESET_CTRL_OFS && PWDATA_I[WAKE_FLAG_BIT]) begin
         nxt_ff.wake_flag = 1'b0;
      end
      if (wake_evt && (SBC_MODE_I == SBC_SLEEP || SBC_MODE_I == SBC_STOP)) begin
         nxt_ff.wake_flag = 1'b1;
      end

      // line drivers and terminations from the filtered fault classes
      nxt_ff.hdrv = (cur_ff.mode == MODE_TRANSMIT_RECEIVE_MODE) && !eff_battery_terminated_mode && !cur_ff.flt[0] && !cur_ff.stuck && !txd_s;
      nxt_ff.ldrv = (cur_ff.mode == MODE_TRANSMIT_RECEIVE_MODE) && !eff_battery_terminated_mode && !cur_ff.flt[1] && !cur_ff.stuck && !txd_s;
      nxt_ff.hterm = !cur_ff.flt[0];
      nxt_ff.lterm = !cur_ff.flt[1];

      // receive pin source selection
      if (eff_battery_terminated_mode) begin
         if (cur_ff.later && (SBC_MODE_I == SBC_NORMAL || SBC_MODE_I == SBC_STANDBY)) begin
            nxt_ff.rxd = !(cur_ff.wake_act || (wake_s && cur_ff.wake_cnt >= WAKE_LIM - CW'(1)));
         end else begin
            nxt_ff.rxd = 1'b1;
         end
      end else if (cur_ff.flt[1]) begin
         nxt_ff.rxd = !se_s[0];
      end else if (cur_ff.flt[0]) begin
         nxt_ff.rxd = !se_s[1];
      end else begin
         nxt_ff.rxd = !diff_s;
      end
   end

   // single state register
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         cur_ff <= '0;
         cur_ff.s1 <= SW'(1); // idle pins: tx recessive, bus quiet, no fault, so no false edge
         cur_ff.s2 <= SW'(1);
         cur_ff.txd_d <= 1'b1;
         cur_ff.mode <= MODE_RST;
         cur_ff.later <= VARIANT_RST;
         cur_ff.gs_sel <= GS_SEL_RST;
         cur_ff.rxd <= 1'b1;
         cur_ff.hterm <= 1'b1;
         cur_ff.lterm <= 1'b1;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   assign PRDATA_O = cur_ff.prdata;
   assign PREADY_O = cur_ff.pready;
   assign PSLVERR_O = cur_ff.pslverr;
   assign RXD_O = cur_ff.rxd;
   assign HIGH_DRV_O = cur_ff.hdrv;
   assign LOW_DRV_O = cur_ff.ldrv;
   assign HIGH_TERM_EN_O = cur_ff.hterm;
   assign LOW_TERM_EN_O = cur_ff.lterm;
   assign NORMAL_REQ_O = cur_ff.nreq;
   assign WAKE_INT_O = cur_ff.wint;
endmodule : can_fault_manager
`default_nettype wire

// [sim/can_fault_props.sv]
// port assertions for the bus fault manager
`timescale 1ns/1ns
`default_nettype none
module can_fault_props #(
   parameter int STUCK_CYCLES = 50, // stuck timeout
   parameter int FILT_CYCLES = 4    // fault filter
) (
   input wire logic SYS_CLK_I,                     // clock
   input wire logic SYS_RST_I,                     // reset
   input wire logic PSEL_I,                        // apb select
   input wire logic PENABLE_I,                     // apb enable
   input wire logic [31:0] PRDATA_O,               // read data
   input wire logic PREADY_O,                      // ready
   input wire logic PSLVERR_O,                     // error
   input wire can_fault_pkg::sbc_mode_t SBC_MODE_I, // chip mode
   input wire logic TXD_I,                         // transmit pin
   input wire logic HIGH_DRV_O,                    // high driver
   input wire logic LOW_DRV_O,                     // low driver
   input wire logic HIGH_TERM_EN_O,                // high termination
   input wire logic LOW_TERM_EN_O,                 // low termination
   input wire logic NORMAL_REQ_O,                  // normal request
   input wire logic WAKE_INT_O                     // wake interrupt
);
   import can_fault_pkg::*;
   int low_cnt;
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // run length of dominant transmit, saturating so it never wraps
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I || TXD_I) low_cnt <= 0;
      else if (low_cnt < STUCK_CYCLES + 8) low_cnt <= low_cnt + 1;
   end
   sequence tx_idle;
      TXD_I [*6];
   endsequence
   sequence low_pwr;
      (SBC_MODE_I == SBC_STOP || SBC_MODE_I == SBC_SLEEP) [*2];
   endsequence
   a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
      else $error("ready longer than one cycle");
   a_setup_answer: assert property ((PSEL_I && !PENABLE_I) |=> PREADY_O)
      else $error("no ready after setup");
   a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error without ready");
   a_idle_rdata: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
      else $error("read data outside access");
   a_high_term_drv: assert property (!HIGH_TERM_EN_O |-> !HIGH_DRV_O)
      else $error("high driver on with termination off");
   a_low_term_drv: assert property (!LOW_TERM_EN_O |-> !LOW_DRV_O)
      else $error("low driver on with termination off");
   a_tx_idle_drv: assert property (tx_idle |-> !HIGH_DRV_O && !LOW_DRV_O)
      else $error("driver on while transmit recessive");
   a_stuck_off: assert property ((low_cnt > STUCK_CYCLES + 6) |-> !HIGH_DRV_O && !LOW_DRV_O)
      else $error("driver on after stuck timeout");
   a_lowpwr_drv: assert property (low_pwr |-> !HIGH_DRV_O && !LOW_DRV_O)
      else $error("driver on in sleep or stop");
   a_req_sleep: assert property (NORMAL_REQ_O |-> $past(SBC_MODE_I) == SBC_SLEEP ##1 !NORMAL_REQ_O)
      else $error("normal request outside sleep");
   a_int_stop: assert property (WAKE_INT_O |-> $past(SBC_MODE_I) == SBC_STOP ##1 !WAKE_INT_O)
      else $error("wake interrupt outside stop");
endmodule : can_fault_props
bind can_fault_manager can_fault_props #(.STUCK_CYCLES(STUCK_CYCLES), .FILT_CYCLES(FILT_CYCLES)) i_props (
   .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SBC_MODE_I(SBC_MODE_I),
   .TXD_I(TXD_I), .HIGH_DRV_O(HIGH_DRV_O), .LOW_DRV_O(LOW_DRV_O), .HIGH_TERM_EN_O(HIGH_TERM_EN_O),
   .LOW_TERM_EN_O(LOW_TERM_EN_O), .NORMAL_REQ_O(NORMAL_REQ_O), .WAKE_INT_O(WAKE_INT_O));
`default_nettype wire

// [sim/can_bus_model.sv]
// behavioural bus with remote nodes, feeding the receivers
`timescale 1ns/1ns
`default_nettype none
module can_bus_model (
   input wire logic clk_i,        // clock
   input wire logic remote_dom_i, // a remote node drives dominant
   input wire logic local_dom_i,  // our drivers are on
   input wire logic open_h_i,     // high wire open
   input wire logic open_l_i,     // low wire open
   output logic diff_dom_o,       // differential receiver
   output logic [1:0] se_dom_o,   // single-ended receivers
   output logic wake_dom_o        // wake comparator
);
   logic dom;
   assign dom = remote_dom_i | local_dom_i;
   // an open wire never leaves recessive on its own receiver
   always_ff @(posedge clk_i) begin
      diff_dom_o <= dom;
      se_dom_o[0] <= dom & ~open_h_i;
      se_dom_o[1] <= dom & ~open_l_i;
      wake_dom_o <= dom;
   end
endmodule : can_bus_model
`default_nettype wire

// [sim/can_fault_manager_tb.sv]
// self-checking bench for the bus fault manager
`timescale 1ns/1ns
`default_nettype none
module can_fault_manager_tb;
   import can_fault_pkg::*;
   localparam int FILT = 4;
   localparam int STUCK = 200;
   logic clk, rst, psel, pen, pwr, err, pready, pslverr, txd, diff, wake, hs, ls, l5;
   logic rxd, hdrv, ldrv, hterm, lterm, nreq, wint, remote, open_h, open_l;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] se;
   logic [3:0] gs;
   sbc_mode_t sbc;
   int error_cnt = 0;
   int total_checks = 0;
   can_fault_manager #(.STUCK_CYCLES(STUCK), .FILT_CYCLES(FILT)) i_dut (
      .SYS_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .SBC_MODE_I(sbc), .TXD_I(txd), .DIFF_DOM_I(diff), .SE_DOM_I(se), .WAKE_DOM_I(wake),
      .HIGH_SHORT_I(hs), .LOW_SHORT_I(ls), .LOW_5V_I(l5), .GS_BELOW_I(gs), .RXD_O(rxd),
      .HIGH_DRV_O(hdrv), .LOW_DRV_O(ldrv), .HIGH_TERM_EN_O(hterm), .LOW_TERM_EN_O(lterm),
      .NORMAL_REQ_O(nreq), .WAKE_INT_O(wint));
   can_bus_model i_bus (.clk_i(clk), .remote_dom_i(remote), .local_dom_i(hdrv | ldrv),
      .open_h_i(open_h), .open_l_i(open_l), .diff_dom_o(diff), .se_dom_o(se), .wake_dom_o(wake));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // one apb transfer; hold everything until ready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (pready !== 1'b1) begin
         error_cnt++;
         finish_test;
      end
      @(posedge clk);
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e);
   endtask : rdchk
   task automatic do_reset;
      rst <= 1'b1;
      tick(20);
      rst <= 1'b0;
      tick(3);
   endtask : do_reset
   task automatic pulses(input int k);
      repeat (k) begin
         remote <= 1'b1;
         tick(15);
         remote <= 1'b0;
         tick(15);
      end
   endtask : pulses
   task automatic t_reset;
      check({rxd, hterm, lterm, hdrv, ldrv}, 5'h1c);
      rdchk(CAN_CTRL_OFS, 32'h4);
      rdchk(RESET_CTRL_OFS, 32'h0);
      rdchk(IO_CTRL_OFS, 32'h0);
      rdchk(FAULT_STAT_OFS, 32'h0);
      apb(1'b1, 8'h10, 32'hffffffff);
      check(err, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
   endtask : t_reset
   // receive-only: faults still tracked, drivers never on
   task automatic t_rxonly;
      apb(1'b1, CAN_CTRL_OFS, 32'h5);
      hs <= 1'b1;
      txd <= 1'b0;
      tick(FILT + 8);
      check({hterm, lterm, hdrv, ldrv}, 4'h4);
      rdchk(FAULT_STAT_OFS, 32'h4);
      hs <= 1'b0;
      txd <= 1'b1;
      tick(FILT + 8);
      check({hterm, lterm}, 2'h3);
      apb(1'b1, CAN_CTRL_OFS, 32'h4);
   endtask : t_rxonly
   // each fault class; the high and low ones with a wire open that would betray the wrong receiver, low to 5v with none
   task automatic t_faults;
      for (int i = 0; i < 3; i++) begin
         {l5, ls, hs} <= 3'h1 << i;
         open_l <= (i == 0);
         open_h <= (i == 1);
         tick(FILT + 8);
         remote <= 1'b1;
         txd <= 1'b0;
         tick(6);
         check({hterm, lterm, hdrv, ldrv}, i == 0 ? 4'h5 : i == 1 ? 4'ha : 4'hf);
         check(rxd, i != 2);
         rdchk(FAULT_STAT_OFS, 32'h4 << i);
         remote <= 1'b0;
         txd <= 1'b1;
         {l5, ls, hs} <= 3'h0;
         tick(FILT + 8);
         check({hterm, lterm}, 2'h3);
         rdchk(FAULT_STAT_OFS, 32'h0);
      end
      {open_h, open_l} <= 2'h0;
   endtask : t_faults
   task automatic t_stuck;
      txd <= 1'b0;
      tick(20);
      check({hdrv, ldrv}, 2'h3);
      tick(STUCK);
      check({hdrv, ldrv}, 2'h0);
      rdchk(RESET_CTRL_OFS, 32'h2);
      txd <= 1'b1;
      tick(300);
      rdchk(RESET_CTRL_OFS, 32'h2);
      tick(40);
      rdchk(RESET_CTRL_OFS, 32'h0);
      txd <= 1'b0;
      tick(6);
      check({hdrv, ldrv}, 2'h3);
      txd <= 1'b1;
   endtask : t_stuck
   // every level, once just above and once just below; repeated reads
   task automatic t_gs;
      for (int n = 0; n < 4; n++) begin
         apb(1'b1, IO_CTRL_OFS, 32'(n));
         for (int b = 0; b < 2; b++) begin
            gs <= b ? 4'h1 << n : ~(4'h1 << n);
            tick(3);
            txd <= 1'b0;
            tick(4);
            txd <= 1'b1;
            tick(2);
            rdchk(IO_CTRL_OFS, 32'(n) | 32'(b << 2));
         end
      end
   endtask : t_gs
   task automatic t_wake;
      int c_req;
      int c_int;
      apb(1'b1, CAN_CTRL_OFS, 32'h6);
      remote <= 1'b1;
      tick(150);
      check(rxd, 1'b1);
      tick(20);
      check(rxd, 1'b0);
      remote <= 1'b0;
      tick(6);
      check(rxd, 1'b1);
      rdchk(RESET_CTRL_OFS, 32'h0);
      apb(1'b1, CAN_CTRL_OFS, 32'h2);
      remote <= 1'b1;
      tick(180);
      check(rxd, 1'b1);
      remote <= 1'b0;
      // back to transmit-receive so that only the chip mode forces battery termination
      apb(1'b1, CAN_CTRL_OFS, 32'h0);
      for (int m = 0; m < 2; m++) begin
         sbc <= m ? SBC_STOP : SBC_SLEEP;
         txd <= 1'b0;
         tick(20);
         check({hdrv, ldrv}, 2'h0);
         txd <= 1'b1;
         remote <= 1'b1;
         c_req = 0;
         c_int = 0;
         repeat (200) begin
            @(posedge clk);
            c_req += (nreq === 1'b1);
            c_int += (wint === 1'b1);
         end
         remote <= 1'b0;
         check(c_req, m == 0);
         check(c_int, m == 1);
         rdchk(RESET_CTRL_OFS, 32'h1);
         apb(1'b1, RESET_CTRL_OFS, 32'h1);
         rdchk(RESET_CTRL_OFS, 32'h0);
      end
      sbc <= SBC_NORMAL;
   endtask : t_wake
   // high wire opened, then restored; end state depends on the variant
   task automatic t_open(input logic v, input logic ow_end);
      do_reset;
      apb(1'b1, CAN_CTRL_OFS, {29'h0, v, 2'h0});
      open_h <= 1'b1;
      pulses(1);
      rdchk(FAULT_STAT_OFS, 32'h0);
      pulses(1);
      rdchk(FAULT_STAT_OFS, 32'h1);
      check({hterm, lterm, rxd}, 3'h7);
      open_h <= 1'b0;
      pulses(3);
      rdchk(FAULT_STAT_OFS, 32'h1);
      pulses(1);
      rdchk(FAULT_STAT_OFS, {31'h0, ow_end});
   endtask : t_open
   initial begin
      {rst, txd, psel, pen, pwr, paddr, pwdata} = {2'h3, 43'h0};
      {hs, ls, l5, gs, remote, open_h, open_l} = 10'h0;
      sbc = SBC_NORMAL;
      @(posedge clk);
      do_reset;
      t_reset;
      t_rxonly;
      t_faults;
      t_stuck;
      t_gs;
      t_wake;
      t_open(1'b0, 1'b0);
      t_open(1'b1, 1'b1);
      finish_test;
   end
endmodule : can_fault_manager_tb
`default_nettype wire
